// ### design/pciu_top.sv
// Pin change interrupt unit: three pin banks, per-pin masks, group
// enables, sticky bank flags and per-bank requests toward the core.
// Assumes a classic Wishbone master on mclk and a core that pulses
// vector_ack when it enters a bank routine.
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`default_nettype none
`timescale 1ns/100ps

module pciu_top
   import pciu_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DW-1:0] wb_dat_i,
   output logic [DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Pad levels, read back even when the pad drives
   input wire logic [BANK_W-1:0] bank2_pins,
   input wire logic [BANK_W-2:0] bank1_pins,
   input wire logic [BANK_W-1:0] bank0_pins,
   // Core interrupt logic
   input wire logic global_irq_enable,
   input wire logic [NBANK-1:0] vector_ack,
   output logic [NBANK-1:0] bank_irq_req,
   output logic irq,
   // Clockless wake request
   output logic wake_req
);

   // Bus handshake state
   pciu_bus_state_type state_q;
   pciu_bus_state_type state_d;
   logic [DW-1:0] rdata_q;

   // Software visible registers
   logic [BANK_W-1:0] gen_q;
   logic [BANK_W-1:0] gen_d;
   logic [BANK_W-1:0] flg_q;
   logic [BANK_W-1:0] flg_d;
   logic [BANK_W-1:0] msk0_q;
   logic [BANK_W-1:0] msk0_d;
   logic [BANK_W-1:0] msk1_q;
   logic [BANK_W-1:0] msk1_d;
   logic [BANK_W-1:0] msk2_q;
   logic [BANK_W-1:0] msk2_d;

   // Pin side
   logic [PINS-1:0] pin_vec;
   logic [PINS-1:0] level;
   logic [PINS-1:0] chg;
   logic [PINS-1:0] mask_all;
   logic [NBANK-1:0] hit;
   logic [NBANK-1:0] set_v;
   logic [NBANK-1:0] clr_v;
   logic [NBANK-1:0] gen_b;
   logic [NBANK-1:0] flg_b;

   // Request decode
   wire req = wb_cyc_i && wb_stb_i;
   wire [AW-1:0] adr_w = wb_adr_i & ADR_WORD;
   wire hit_gen = (adr_w == ADR_GEN);
   wire hit_flg = (adr_w == ADR_FLG);
   wire hit_msk0 = (adr_w == ADR_MSK0);
   wire hit_msk1 = (adr_w == ADR_MSK1);
   wire hit_msk2 = (adr_w == ADR_MSK2);

   // Writes land on the ack edge, only when byte lane 0 is enabled
   wire wr_fire = (state_q == BUS_ACK) && req && wb_we_i && wb_sel_i[0];
   wire wr_gen = wr_fire && hit_gen;
   wire wr_flg = wr_fire && hit_flg;
   wire wr_msk0 = wr_fire && hit_msk0;
   wire wr_msk1 = wr_fire && hit_msk1;
   wire wr_msk2 = wr_fire && hit_msk2;
   wire [BANK_W-1:0] wbyte = wb_dat_i[BANK_W-1:0];

   // Read mux; unmapped offsets read zero
   wire [BANK_W-1:0] rd_byte =
      hit_gen ? gen_q :
      hit_flg ? flg_q :
      hit_msk0 ? msk0_q :
      hit_msk1 ? msk1_q :
      hit_msk2 ? msk2_q : RST_REG;
   wire [DW-1:0] rd_word = {{(DW-BANK_W){1'b0}}, rd_byte};

   // Reserved bits are never stored, so they always read zero
   assign gen_d = wr_gen ? (wbyte & GEN_USED) : gen_q;
   assign msk0_d = wr_msk0 ? wbyte : msk0_q;
   assign msk1_d = wr_msk1 ? (wbyte & MSK1_USED) : msk1_q;
   assign msk2_d = wr_msk2 ? wbyte : msk2_q;

   // Handshake: one idle cycle, then ack for one cycle
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         BUS_IDLE: begin
            if (req) begin
               state_d = BUS_ACK;
            end
         end
         BUS_ACK: begin
            state_d = BUS_IDLE;
         end
         default: begin
            state_d = BUS_IDLE;
         end
      endcase
   end

   // Bus state and registered read data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= BUS_IDLE;
         rdata_q <= RST_DATA;
      end else begin
         state_q <= state_d;
         if (state_q == BUS_IDLE && req) begin
            rdata_q <= rd_word;
         end
      end
   end

   assign wb_ack_o = (state_q == BUS_ACK);
   assign wb_dat_o = rdata_q;

   // Configuration registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gen_q <= RST_REG;
         msk0_q <= RST_REG;
         msk1_q <= RST_REG;
         msk2_q <= RST_REG;
      end else begin
         gen_q <= gen_d;
         msk0_q <= msk0_d;
         msk1_q <= msk1_d;
         msk2_q <= msk2_d;
      end
   end

   // Bank 1 has no pin 15; a constant there never changes
   assign pin_vec = {bank2_pins, RST_BIT, bank1_pins, bank0_pins};
   assign mask_all = {msk2_q, msk1_q, msk0_q};

   // One synchroniser per pin position
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         pciu_sync u_sync (
            .mclk(mclk),
            .rst(rst),
            .pin_i(pin_vec[g]),
            .level_o(level[g]),
            .change_o(chg[g])
         );
      end
   endgenerate

   // Per bank: masked change, gated by the group enable
   genvar b;
   generate
      for (b = 0; b < NBANK; b++) begin : g_bank
         assign hit[b] = |(chg[b*BANK_W +: BANK_W] & mask_all[b*BANK_W +: BANK_W]);
         assign gen_b[b] = gen_q[b];
         assign flg_b[b] = flg_q[b];
      end
   endgenerate

   assign set_v[BANK2_BIT] = hit[BANK2_BIT] && gen_b[BANK2_BIT];
   assign set_v[BANK1_BIT] = hit[BANK1_BIT] && gen_b[BANK1_BIT];
   assign set_v[BANK0_BIT] = hit[BANK0_BIT] && gen_b[BANK0_BIT];

   // Clears come from a written one or from vector entry
   assign clr_v = (wr_flg ? wbyte[NBANK-1:0] : RST_BANK) | vector_ack;
   // Set wins so no change is lost during a clear
   assign flg_d = {{(BANK_W-NBANK){1'b0}}, (flg_b & ~clr_v) | set_v};

   // Sticky bank flags
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flg_q <= RST_REG;
      end else begin
         flg_q <= flg_d;
      end
   end

   // Core requests need the I-bit; the level irq line does not
   assign bank_irq_req = flg_b & gen_b & {NBANK{global_irq_enable}};
   assign irq = |(flg_b & gen_b);

   // Wake path works while mclk is stopped
   pciu_wake u_wake (
      .pin_i(pin_vec),
      .level_i(level),
      .mask_i(mask_all),
      .gen_i(gen_b),
      .wake_o(wake_req)
   );

   // Checks on the block's own behaviour
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // Bus request and its single ack
   sequence s_req;
      state_q == BUS_IDLE && req;
   endsequence

   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_ack;
      s_req |=> s_ack_once;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack not a one-cycle answer");

   // Bank 2 change with enable sets its flag next edge
   property p_bank2_set;
      (hit[BANK2_BIT] && gen_q[BANK2_BIT]) |=> flg_q[BANK2_BIT];
   endproperty
   a_bank2_set: assert property (p_bank2_set)
      else $error("bank 2 change lost");

   property p_bank1_set;
      (hit[BANK1_BIT] && gen_q[BANK1_BIT]) |=> flg_q[BANK1_BIT];
   endproperty
   a_bank1_set: assert property (p_bank1_set)
      else $error("bank 1 change lost");

   property p_bank0_set;
      (hit[BANK0_BIT] && gen_q[BANK0_BIT]) |=> flg_q[BANK0_BIT];
   endproperty
   a_bank0_set: assert property (p_bank0_set)
      else $error("bank 0 change lost");

   // The bank 1 flag only rises from an enabled, unmasked change
   property p_flag_cause;
      $rose(flg_q[BANK1_BIT]) |->
         $past(|(chg[15:8] & msk1_q)) && $past(gen_q[BANK1_BIT]);
   endproperty
   a_flag_cause: assert property (p_flag_cause)
      else $error("bank 1 flag rose with no cause");

   // Without the I-bit no bank 2 request reaches the core
   property p_req_gate;
      (flg_q[BANK2_BIT] && gen_q[BANK2_BIT]) |->
         (bank_irq_req[BANK2_BIT] == global_irq_enable);
   endproperty
   a_req_gate: assert property (p_req_gate)
      else $error("bank 2 request not gated by I-bit");

   // Vector entry clears the flag unless a new change lands
   property p_vec_clr;
      (vector_ack[BANK0_BIT] && !set_v[BANK0_BIT]) |=> !flg_q[BANK0_BIT];
   endproperty
   a_vec_clr: assert property (p_vec_clr)
      else $error("vector entry left flag set");

   // A written zero keeps a set flag
   property p_w1c_zero;
      (wr_flg && !wbyte[BANK1_BIT] && flg_q[BANK1_BIT]
         && !vector_ack[BANK1_BIT]) |=> flg_q[BANK1_BIT];
   endproperty
   a_w1c_zero: assert property (p_w1c_zero)
      else $error("written zero cleared a flag");

   // Reserved mask bit reads zero on the bus
   property p_msk1_rsv;
      (s_req ##0 (hit_msk1 && !wb_we_i)) |=> !wb_dat_o[MSK1_RSV_BIT];
   endproperty
   a_msk1_rsv: assert property (p_msk1_rsv)
      else $error("bank 1 mask bit 7 not zero");

   // Reserved enable and flag bits read zero
   property p_rsv;
      (s_req ##0 ((hit_gen || hit_flg) && !wb_we_i)) |=>
         (wb_dat_o[RSV_HI:RSV_LO] == 5'h00);
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved bits read nonzero");

   // Masked pin never sets bank 0
   property p_mask_off;
      (msk0_q == RST_REG && !flg_q[BANK0_BIT]) |=> !flg_q[BANK0_BIT];
   endproperty
   a_mask_off: assert property (p_mask_off)
      else $error("masked bank 0 set its flag");

   // Set beats a same-cycle clear
   property p_set_wins;
      (set_v[BANK2_BIT] && clr_v[BANK2_BIT]) |=> flg_q[BANK2_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a set");

   // Bank 2 mask bit zero blocks its pin from the flag
   property p_msk2_gate;
      (chg[16] && !msk2_q[0] && !(|(chg[23:17] & msk2_q[7:1]))
         && !flg_q[BANK2_BIT]) |=> !flg_q[BANK2_BIT];
   endproperty
   a_msk2_gate: assert property (p_msk2_gate)
      else $error("masked bank 2 pin set flag");

   // Bank 0 enable off blocks the flag
   property p_gen0_off;
      (!gen_q[BANK0_BIT] && !flg_q[BANK0_BIT]) |=> !flg_q[BANK0_BIT];
   endproperty
   a_gen0_off: assert property (p_gen0_off)
      else $error("disabled bank 0 set its flag");

endmodule : pciu_top

`default_nettype wire

// ### common/pciu_pkg.sv
// Shared constants for the pin change interrupt unit.
// Assumes a 32-bit classic Wishbone slave port and one 100 MHz clock.
`default_nettype none

package pciu_pkg;

   // Structure of the pin field
   localparam int NBANK = 3;
   localparam int BANK_W = 8;
   localparam int PINS = NBANK * BANK_W;
   localparam int DW = 32;
   localparam int AW = 8;

   // Register byte offsets
   localparam logic [AW-1:0] ADR_GEN = 8'h00;
   localparam logic [AW-1:0] ADR_FLG = 8'h04;
   localparam logic [AW-1:0] ADR_MSK0 = 8'h08;
   localparam logic [AW-1:0] ADR_MSK1 = 8'h0c;
   localparam logic [AW-1:0] ADR_MSK2 = 8'h10;
   localparam logic [AW-1:0] ADR_WORD = 8'hfc;

   // Bank bit positions in enable and flag registers
   localparam int BANK0_BIT = 0;
   localparam int BANK1_BIT = 1;
   localparam int BANK2_BIT = 2;
   localparam int RSV_LO = 3;
   localparam int RSV_HI = 7;
   localparam int MSK1_RSV_BIT = 7;

   // Writable bits of each register
   localparam logic [BANK_W-1:0] GEN_USED = 8'h07;
   localparam logic [BANK_W-1:0] MSK1_USED = 8'h7f;

   // Reset values
   localparam logic [BANK_W-1:0] RST_REG = 8'h00;
   localparam logic [NBANK-1:0] RST_BANK = 3'h0;
   localparam logic [DW-1:0] RST_DATA = 32'h0000_0000;
   localparam logic RST_BIT = 1'b0;

   // Bus handshake phases
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } pciu_bus_state_type;

endpackage : pciu_pkg

`default_nettype wire

// ### design/pciu_sync.sv
// Three-stage pin synchroniser with a settled level and a change pulse.
// Assumes the pin is asynchronous to mclk; one instance per pin.
`default_nettype none
`timescale 1ns/100ps

module pciu_sync
   import pciu_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Raw pad level
   input wire logic pin_i,
   // Settled level and one-cycle change pulse
   output logic level_o,
   output logic change_o
);

   // Edges needed before stage three holds a real pin sample
   localparam int STAGES = 3;

   logic [STAGES-1:0] fill_q;
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;
   logic seen_q;
   logic chg_q;

   // A change counts only once stages two and three agree
   wire agree = (s2_q == s3_q);
   // First settled sample after reset only loads, no spurious change
   wire moved = agree && seen_q && (s3_q != lvl_q);

   // Stage one feeds stage two and nothing else
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_q <= RST_BIT;
         s2_q <= RST_BIT;
         s3_q <= RST_BIT;
         lvl_q <= RST_BIT;
         seen_q <= RST_BIT;
         chg_q <= RST_BIT;
         fill_q <= '0;
      end else begin
         fill_q <= {fill_q[STAGES-2:0], ~RST_BIT};
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (agree) begin
            lvl_q <= s3_q;
         end
         // Reset values in the stages must not pose as a pin level
         seen_q <= seen_q | (agree && fill_q[STAGES-1]);
         chg_q <= moved;
      end
   end

   assign level_o = lvl_q;
   assign change_o = chg_q;

endmodule : pciu_sync

`default_nettype wire

// ### design/pciu_wake.sv
// Clockless change detector used as a wake request while mclk is stopped.
// Assumes settled levels hold their last value when the clock halts.
`default_nettype none
`timescale 1ns/100ps

module pciu_wake
   import pciu_pkg::*;
(
   // Raw pins and their last settled levels
   input wire logic [PINS-1:0] pin_i,
   input wire logic [PINS-1:0] level_i,
   // Per-pin masks and bank group enables
   input wire logic [PINS-1:0] mask_i,
   input wire logic [NBANK-1:0] gen_i,
   // Asynchronous wake request
   output logic wake_o
);

   logic [PINS-1:0] arm;

   // A pin is armed only with its mask and bank enable
   genvar b;
   generate
      for (b = 0; b < NBANK; b++) begin : g_arm
         assign arm[b*BANK_W +: BANK_W] = mask_i[b*BANK_W +: BANK_W]
                                        & {BANK_W{gen_i[b]}};
      end
   endgenerate

   // Pure gates, so it works with no clock at all
   assign wake_o = |((pin_i ^ level_i) & arm);

endmodule : pciu_wake

`default_nettype wire

// ### dv/pciu_core_model.sv
// Behavioural model of the core's interrupt entry for the pin change unit.
// Assumes level requests on mclk; enters a routine after a set latency.
`default_nettype none
`timescale 1ns/100ps

module pciu_core_model
   import pciu_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Requests from the unit and model controls
   input wire logic [NBANK-1:0] bank_irq_req,
   input wire logic take_en,
   input wire logic [3:0] latency,
   // Routine entry pulses
   output logic [NBANK-1:0] vector_ack
);
   logic [3:0] cnt_q;
   logic [NBANK-1:0] pick;

   // Lowest requesting bank goes first
   assign pick = bank_irq_req & (~bank_irq_req + 3'h1);

   // Idle one cycle after each entry so a stale request is not taken twice
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         vector_ack <= 3'h0;
      end else begin
         vector_ack <= 3'h0;
         if (vector_ack != 3'h0 || !take_en || bank_irq_req == 3'h0) begin
            cnt_q <= 4'h0;
         end else if (cnt_q == latency) begin
            vector_ack <= pick;
            cnt_q <= 4'h0;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule : pciu_core_model
`default_nettype wire

// ### dv/pciu_top_tb.sv
// Self-checking bench for the pin change interrupt unit.
// Assumes the core model answers requests; bus tasks speak classic Wishbone.
`default_nettype none
`timescale 1ns/100ps

module pciu_top_tb
   import pciu_pkg::*;
;
   typedef struct {logic [AW-1:0] a; logic [DW-1:0] d; logic [DW-1:0] e;} pciu_row_type;
   logic mclk, rst, cyc, stb, we, ack, gie, irq, wake, take_en;
   logic [AW-1:0] adr;
   logic [3:0] sel, lat;
   logic [DW-1:0] wdat, rdat, rd;
   logic [PINS-1:0] pins;
   logic [NBANK-1:0] vack, req;
   int n_errors, total_checks, cycles, idx;
   logic [AW-1:0] radr [5] = '{ADR_GEN, ADR_FLG, ADR_MSK0, ADR_MSK1, ADR_MSK2};
   pciu_row_type rows [6] = '{
      '{ADR_MSK0, 32'h0000_00a5, 32'h0000_00a5},
      '{ADR_MSK1, 32'h0000_00ff, 32'h0000_007f},
      '{ADR_MSK2, 32'h0000_005a, 32'h0000_005a},
      '{ADR_GEN, 32'h0000_00ff, 32'h0000_0007},
      '{ADR_FLG, 32'h0000_00ff, 32'h0000_0000},
      '{8'h14, 32'h0000_00ff, 32'h0000_0000}};

   pciu_top pciu_top_inst (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .bank2_pins(pins[23:16]), .bank1_pins(pins[14:8]),
      .bank0_pins(pins[7:0]), .global_irq_enable(gie), .vector_ack(vack),
      .bank_irq_req(req), .irq(irq), .wake_req(wake));

   pciu_core_model pciu_core_model_inst (.mclk(mclk), .rst(rst), .bank_irq_req(req),
      .take_en(take_en), .latency(lat), .vector_ack(vack));

   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 6000) begin
         n_errors++;
         summarize();
      end
   end

   task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One classic cycle; read data taken at the ack edge
   task wb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   // Pins are driven by the port itself, as an output would
   task tog(input int i);
      @(posedge mclk);
      pins[i] <= ~pins[i];
      #1;
   endtask : tog

   task wait_irq();
      for (int k = 0; k < 12 && irq !== 1'b1; k++) @(posedge mclk);
   endtask : wait_irq

   task summarize();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   initial begin
      rst = 1'b1;
      {cyc, stb, we, gie, take_en} = 5'h00;
      adr = 8'h00;
      sel = 4'h1;
      lat = 4'h0;
      wdat = 32'h0000_0000;
      pins = 24'h00_00_00;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      // Reset values, then the write/read table
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, radr[i], 32'h0);
         chk(rd, {24'h0, RST_REG});
      end
      foreach (rows[i]) begin
         wb(1'b1, rows[i].a, rows[i].d);
         wb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].e);
      end
      // Edge pins of each bank set the flag; I-bit off holds the request
      wb(1'b1, ADR_MSK0, 32'hff);
      wb(1'b1, ADR_MSK1, 32'hff);
      wb(1'b1, ADR_MSK2, 32'hff);
      // A write without byte lane 0 changes nothing
      sel <= 4'he;
      wb(1'b1, ADR_MSK0, 32'h00);
      sel <= 4'h1;
      wb(1'b0, ADR_MSK0, 32'h0);
      chk(rd, 32'h0000_00ff);
      for (int b = 0; b < 3; b++) begin
         for (int h = 0; h < 2; h++) begin
            idx = 8 * b + (h == 0 ? 0 : (b == 1 ? 6 : 7));
            tog(idx);
            chk(wake, 1'b1);
            wait_irq();
            chk(irq, 1'b1);
            chk(req, 3'h0);
            wb(1'b0, ADR_FLG, 32'h0);
            chk(rd, 32'h1 << b);
            wb(1'b1, ADR_FLG, 32'h0);
            wb(1'b0, ADR_FLG, 32'h0);
            chk(rd, 32'h1 << b);
            wb(1'b1, ADR_FLG, 32'h1 << b);
            wb(1'b0, ADR_FLG, 32'h0);
            chk(rd, 32'h0);
         end
      end
      // Masked pin, then a disabled group, leave no flag
      wb(1'b1, ADR_MSK0, 32'hfe);
      tog(0);
      repeat (12) @(posedge mclk);
      wb(1'b0, ADR_FLG, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, ADR_GEN, 32'h06);
      tog(1);
      repeat (12) @(posedge mclk);
      wb(1'b0, ADR_FLG, 32'h0);
      chk(rd, 32'h0);
      // Change pulse and written-one clear meet on one edge
      tog(17);
      repeat (2) @(posedge mclk);
      wb(1'b1, ADR_FLG, 32'h4);
      wb(1'b0, ADR_FLG, 32'h0);
      chk(rd, 32'h4);
      wb(1'b1, ADR_FLG, 32'h4);
      // Routine entry clears the flag; prompt and slow core
      wb(1'b1, ADR_GEN, 32'h07);
      @(posedge mclk);
      gie <= 1'b1;
      take_en <= 1'b1;
      for (int b = 0; b < 3; b++) begin
         lat <= (b == 1) ? 4'h5 : 4'h0;
         tog(8 * b + 1);
         for (int k = 0; k < 12 && req === 3'h0; k++) @(posedge mclk);
         chk(req, 3'h1 << b);
         for (int k = 0; k < 12 && req !== 3'h0; k++) @(posedge mclk);
         wb(1'b0, ADR_FLG, 32'h0);
         chk(rd, 32'h0);
      end
      // Reset in mid-run
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      wb(1'b0, ADR_GEN, 32'h0);
      chk(rd, {24'h0, RST_REG});
      summarize();
   end
endmodule : pciu_top_tb
`default_nettype wire
